// file: core/emb_consts.svh
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

// pin cycle lengths in oscillator periods
`define EMB_FETCH_PERIODS 3
`define EMB_DATA_PERIODS 6
// last phase index of each cycle kind
`define EMB_FETCH_LAST 3'h2
`define EMB_DATA_LAST 3'h5
// data strobe window
`define EMB_STROBE_FIRST 3'h2
`define EMB_STROBE_LAST 3'h4
// read strobe is port 3 bit 7, write strobe is port 3 bit 6
`define EMB_RD_PORT3_BIT 7
`define EMB_WR_PORT3_BIT 6
// value forced into the port 0 latch on an external access
`define EMB_PORT0_FILL 8'hFF
// highest internal code address
`define EMB_INT_CODE_TOP 16'h1FFF
// latch pulse allow bit after reset
`define EMB_ALLOW_RESET 1'h1
// last count of the port 0 input synchroniser drain (two cycles)
`define EMB_SYNC_LAST 2'h1

`endif

// file: core/emb_core.sv
// Behaviour
// - program fetches strobe memory with the program fetch strobe only.
// - data accesses strobe with read (port 3 bit 7) and write (bit 6).
// - program fetches always present the full 16-bit address.
// - data pointer form uses 16-bit address, indirect register form 8-bit.
// - port zero carries low address byte, then data byte.
// - port zero as bus is driven both ways, no pullups needed.
// - every external access loads all ones into the port zero latch.
// - 16-bit cycles drive high address on port two; latch left unchanged.
// - 8-bit data cycles keep the port two latch on the pins.
// - port two strong pullup stays on for ones the whole cycle.
// - clearing the latch pulse allow bit gates off fetch latch pulses while code select pin high.
// - internal code and bit cleared: pulses only for data moves.
// - latch pulse generation is enabled after hardware reset.
// - fetch externally when code select pin low or address above 1FFF.
// - data cycle takes six oscillator periods, fetch cycle three.
`timescale 1ns/1ps
`default_nettype none
`include "emb_consts.svh"

module emb_core (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   // access request from the cpu core
   input wire logic req,
   input wire logic [1:0] req_kind,
   input wire logic req_short,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_wdata,
   // cpu state
   input wire logic [15:0] pc,
   input wire logic [7:0] port_two_latch,
   // system_config_reg write
   input wire logic cfg_wr,
   input wire logic cfg_latch_pulse_allow,
   // answers to the cpu core
   output logic req_ready,
   output logic done,
   output logic [7:0] rdata,
   output logic code_external,
   output logic port_zero_latch_fill,
   output logic latch_pulse_allow,
   // pins
   input wire logic external_code_select_n,
   input wire logic [7:0] port_zero_in,
   output logic [7:0] port_zero_out,
   output logic port_zero_oe,
   output logic [7:0] port_two_out,
   output logic [7:0] port_two_pullup,
   output logic latch_pulse,
   output logic program_fetch_strobe_n,
   output logic read_strobe_n,
   output logic write_strobe_n
);

   emb_pkg::emb_state_e state_q;
   emb_pkg::emb_state_e state_d;
   logic [2:0] phase_q;
   logic [1:0] sync_cnt_q;
   logic [1:0] kind_q;
   logic short_q;
   logic [15:0] addr_q;
   logic [7:0] wdata_q;
   logic ea_n_s;
   logic [7:0] p0_s;

   emb_sync #(.WIDTH(1)) u_ea_sync (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .pin_in(external_code_select_n),
      .sync_out(ea_n_s)
   );

   emb_sync #(.WIDTH(8)) u_p0_sync (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .pin_in(port_zero_in),
      .sync_out(p0_s)
   );

   wire accept = req && (state_q == emb_pkg::EMB_ST_IDLE);
   wire run = (state_q == emb_pkg::EMB_ST_RUN);
   wire is_fetch = (kind_q == emb_pkg::EMB_FETCH);
   wire is_read = (kind_q == emb_pkg::EMB_READ);
   wire is_write = (kind_q == emb_pkg::EMB_WRITE);
   wire [2:0] last_phase = is_fetch ? `EMB_FETCH_LAST : `EMB_DATA_LAST;
   wire in_strobe = (phase_q >= `EMB_STROBE_FIRST) && (phase_q <= `EMB_STROBE_LAST);
   wire sync_end = (state_q == emb_pkg::EMB_ST_SYNC) && (sync_cnt_q == `EMB_SYNC_LAST);
   // ea low forces pulses; otherwise the allow bit gates fetch pulses
   wire ale_gate = !is_fetch || !ea_n_s || latch_pulse_allow;
   wire ale_d = run && (phase_q == 3'h0) && ale_gate;
   wire program_fetch_strobe_n_d = !(run && is_fetch && (phase_q != 3'h0));
   wire rd_n_d = !(run && is_read && in_strobe);
   wire wr_n_d = !(run && is_write && in_strobe);
   // reads keep the address one more period for hold after the pulse falls
   wire addr_hold = (is_fetch || is_write) ? (phase_q == 3'h0) : (phase_q <= 3'h1);
   wire [7:0] p0_d = addr_hold ? addr_q[7:0] : wdata_q;
   wire p0_oe_d = run && (addr_hold || is_write);
   wire wide = is_fetch || !short_q;
   wire [7:0] p2_d = (run && wide) ? addr_q[15:8] : port_two_latch;
   wire [7:0] p2_pu_d = run ? p2_d : 8'h00;
   wire code_ext_d = !ea_n_s || (pc > `EMB_INT_CODE_TOP);

   always_comb begin
      state_d = state_q;
      case (state_q)
         emb_pkg::EMB_ST_IDLE: begin
            if (req) begin
               state_d = emb_pkg::EMB_ST_RUN;
            end
         end
         emb_pkg::EMB_ST_RUN: begin
            if (phase_q == last_phase) begin
               state_d = emb_pkg::EMB_ST_SYNC;
            end
         end
         emb_pkg::EMB_ST_SYNC: begin
            if (sync_cnt_q == `EMB_SYNC_LAST) begin
               state_d = emb_pkg::EMB_ST_IDLE;
            end
         end
         default: begin
            state_d = emb_pkg::EMB_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q <= emb_pkg::EMB_ST_IDLE;
         phase_q <= 3'h0;
         sync_cnt_q <= 2'h0;
      end else if (ce) begin
         state_q <= state_d;
         phase_q <= run ? phase_q + 3'h1 : 3'h0;
         sync_cnt_q <= (state_q == emb_pkg::EMB_ST_SYNC) ? sync_cnt_q + 2'h1 : 2'h0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         kind_q <= 2'h0;
         short_q <= 1'h0;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
      end else if (ce && accept) begin
         kind_q <= req_kind;
         short_q <= req_short && (req_kind != emb_pkg::EMB_FETCH);
         addr_q <= req_addr;
         wdata_q <= req_wdata;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         latch_pulse_allow <= `EMB_ALLOW_RESET;
      end else if (ce && cfg_wr) begin
         latch_pulse_allow <= cfg_latch_pulse_allow;
      end
   end

   // pins are registered, so they trail the phase counter by one period
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         latch_pulse <= 1'h0;
         program_fetch_strobe_n <= 1'h1;
         read_strobe_n <= 1'h1;
         write_strobe_n <= 1'h1;
         port_zero_out <= 8'h00;
         port_zero_oe <= 1'h0;
         port_two_out <= 8'h00;
         port_two_pullup <= 8'h00;
      end else if (ce) begin
         latch_pulse <= ale_d;
         program_fetch_strobe_n <= program_fetch_strobe_n_d;
         read_strobe_n <= rd_n_d;
         write_strobe_n <= wr_n_d;
         port_zero_out <= p0_d;
         port_zero_oe <= p0_oe_d;
         port_two_out <= p2_d;
         port_two_pullup <= p2_pu_d;
      end
   end

   // read data taken after the synchroniser has caught the last strobe period
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         req_ready <= 1'h0;
         done <= 1'h0;
         rdata <= 8'h00;
         code_external <= 1'h0;
         port_zero_latch_fill <= 1'h0;
      end else if (ce) begin
         req_ready <= (state_d == emb_pkg::EMB_ST_IDLE);
         done <= sync_end;
         if (sync_end && !is_write) begin
            rdata <= p0_s;
         end
         code_external <= code_ext_d;
         port_zero_latch_fill <= accept;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn || !ce);

   chk_fetch_strobe_only: assert property (
      !program_fetch_strobe_n |-> read_strobe_n && write_strobe_n)
      else $error("fetch strobe overlaps a data strobe");
   chk_data_strobe_kind: assert property (
      !read_strobe_n || !write_strobe_n |-> !is_fetch)
      else $error("data strobe during a program fetch");
   chk_fetch_full_addr: assert property (
      !program_fetch_strobe_n |-> port_two_out == addr_q[15:8])
      else $error("fetch without high address on port two");
   chk_long_data_addr: assert property (
      (!read_strobe_n || !write_strobe_n) && !short_q |-> port_two_out == addr_q[15:8])
      else $error("data pointer access without high address");
   chk_short_page: assert property (
      (!read_strobe_n || !write_strobe_n) && short_q |-> port_two_out == $past(port_two_latch))
      else $error("indirect access did not keep the port two latch");
   chk_addr_on_pulse: assert property (
      latch_pulse |-> port_zero_oe && port_zero_out == addr_q[7:0])
      else $error("latch pulse without low address on port zero");
   chk_write_data: assert property (
      !write_strobe_n |-> port_zero_oe && port_zero_out == wdata_q)
      else $error("write strobe without driven data");
   chk_fill_pulse: assert property (
      accept |=> port_zero_latch_fill ##1 !port_zero_latch_fill)
      else $error("port zero fill not pulsed on access");
   chk_pullup_whole: assert property (
      !read_strobe_n || !write_strobe_n |-> port_two_pullup == port_two_out)
      else $error("port two pullup dropped during cycle");
   chk_pulse_gated: assert property (
      latch_pulse && is_fetch |-> $past(latch_pulse_allow) || !$past(ea_n_s))
      else $error("fetch latch pulse while gated off");
   chk_data_pulse: assert property (
      accept && req_kind != emb_pkg::EMB_FETCH |-> ##2 latch_pulse)
      else $error("data move without latch pulse");
   // first edge out of reset or a frozen cycle has no valid previous sample
   chk_code_select: assert property (
      $past(resetn) && $past(ce) |->
      code_external == (!$past(ea_n_s) || $past(pc) > `EMB_INT_CODE_TOP))
      else $error("external code select wrong");
   chk_read_length: assert property (
      accept && req_kind == emb_pkg::EMB_READ |->
      ##4 !read_strobe_n [*3] ##1 read_strobe_n ##2 done)
      else $error("read cycle length wrong");
   chk_fetch_length: assert property (
      accept && req_kind == emb_pkg::EMB_FETCH |->
      ##3 !program_fetch_strobe_n [*2] ##1 program_fetch_strobe_n)
      else $error("fetch cycle length wrong");

   cov_fetch: cover property (accept && req_kind == emb_pkg::EMB_FETCH ##[1:8] done);
   cov_short_read: cover property (
      accept && req_kind == emb_pkg::EMB_READ && req_short ##[1:12] done);
   cov_write: cover property (accept && req_kind == emb_pkg::EMB_WRITE ##[1:12] done);
   cov_gated_fetch: cover property (
      accept && req_kind == emb_pkg::EMB_FETCH && !latch_pulse_allow && ea_n_s);

endmodule // emb_core

`default_nettype wire

// file: core/emb_pkg.sv
`default_nettype none

package emb_pkg;

   typedef enum logic [2:0] {
      EMB_ST_IDLE = 3'b001,
      EMB_ST_RUN = 3'b010,
      EMB_ST_SYNC = 3'b100
   } emb_state_e;

   typedef enum logic [1:0] {
      EMB_FETCH = 2'h0,
      EMB_READ = 2'h1,
      EMB_WRITE = 2'h2
   } emb_kind_e;

endpackage

`default_nettype wire

// file: core/emb_sync.sv
`timescale 1ns/1ps
`default_nettype none

module emb_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   // pin side
   input wire logic [WIDTH-1:0] pin_in,
   // clock side
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_q;

   // stage1_q feeds only the second flop
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stage1_q <= '0;
         sync_out <= '0;
      end else if (ce) begin
         stage1_q <= pin_in;
         sync_out <= stage1_q;
      end
   end

endmodule // emb_sync

`default_nettype wire

// file: verif/emb_mem.sv
`timescale 1ns/1ps
`default_nettype none

module emb_mem (
   // clock
   input wire logic clock,
   // bus from the block
   input wire logic [7:0] port_zero_out,
   input wire logic port_zero_oe,
   input wire logic [7:0] port_two_out,
   input wire logic latch_pulse,
   input wire logic program_fetch_strobe_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   // pin level and captured write
   output logic [7:0] port_zero_in,
   output logic [15:0] wr_addr,
   output logic [7:0] wr_data
);
   logic [7:0] lo_q = 8'h00;
   logic [7:0] last_q = 8'h00;
   wire logic drive = !(program_fetch_strobe_n && read_strobe_n);
   wire logic [7:0] mem_val = lo_q ^ port_two_out ^ (program_fetch_strobe_n ? 8'h5A : 8'hA5);
   // released bus toggles, so a sample one period late never finds the old byte
   assign port_zero_in = port_zero_oe ? port_zero_out : (drive ? mem_val : ~last_q);
   always @(posedge clock) begin
      last_q <= port_zero_in;
      if (latch_pulse) lo_q <= port_zero_out;
      if (!write_strobe_n) begin
         wr_addr <= {port_two_out, lo_q};
         wr_data <= port_zero_out;
      end
   end
endmodule // emb_mem

`default_nettype wire

// file: verif/tb_external_memory_bus_interface.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_external_memory_bus_interface;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic req = 1'b0;
   logic [1:0] req_kind = 2'h0;
   logic req_short = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0] req_wdata = 8'h00;
   logic [15:0] pc = 16'h0000;
   logic [7:0] p2_latch = 8'h96;
   logic cfg_wr = 1'b0;
   logic cfg_val = 1'b1;
   logic ecs_n = 1'b0;
   logic ce = 1'b1;
   wire logic [7:0] p0_in, p0_out, p2_out, p2_pu, rdata, wr_data;
   wire logic [15:0] wr_addr;
   wire logic req_ready, done, code_ext, fill, allow, p0_oe, lp, fetch_n, read_n, write_n;
   int error_cnt = 0;
   int n_compared = 0;

   initial forever #25 clock = ~clock;

   emb_core dut_u (.clock(clock), .resetn(resetn), .ce(ce), .req(req), .req_kind(req_kind),
      .req_short(req_short), .req_addr(req_addr), .req_wdata(req_wdata), .pc(pc),
      .port_two_latch(p2_latch), .cfg_wr(cfg_wr), .cfg_latch_pulse_allow(cfg_val),
      .req_ready(req_ready), .done(done), .rdata(rdata), .code_external(code_ext),
      .port_zero_latch_fill(fill), .latch_pulse_allow(allow), .external_code_select_n(ecs_n),
      .port_zero_in(p0_in), .port_zero_out(p0_out), .port_zero_oe(p0_oe),
      .port_two_out(p2_out), .port_two_pullup(p2_pu), .latch_pulse(lp),
      .program_fetch_strobe_n(fetch_n), .read_strobe_n(read_n), .write_strobe_n(write_n));

   emb_mem mem_u (.clock(clock), .port_zero_out(p0_out), .port_zero_oe(p0_oe),
      .port_two_out(p2_out), .latch_pulse(lp), .program_fetch_strobe_n(fetch_n),
      .read_strobe_n(read_n), .write_strobe_n(write_n), .port_zero_in(p0_in),
      .wr_addr(wr_addr), .wr_data(wr_data));

   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic wait_ready;
      int i;
      for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clock);
      if (req_ready !== 1'b1) begin
         error_cnt++;
         close_out();
      end
   endtask

   // one access; ends at the done cycle so a next call is back to back
   task automatic acc(input logic [1:0] k, input logic s, input logic [15:0] a,
      input logic [7:0] w, input int nl_exp);
      int c, nf, nr, nw, nl;
      logic [7:0] hi;
      hi = (s && k != 2'h0) ? p2_latch : a[15:8];
      wait_ready();
      req_kind = k;
      req_short = s;
      req_addr = a;
      req_wdata = w;
      req = 1'b1;
      @(negedge clock);
      req = 1'b0;
      c = 1;
      nf = 0;
      nr = 0;
      nw = 0;
      nl = 0;
      while (done !== 1'b1 && c < 12) begin
         if (c == 1) `CHK(fill, 1'b1)
         if (c == 2 && nl_exp > 0) `CHK({p0_oe, p0_out}, {1'b1, a[7:0]})
         nf += (fetch_n === 1'b0);
         nr += (read_n === 1'b0);
         nw += (write_n === 1'b0);
         nl += (lp === 1'b1);
         if (fetch_n !== 1'b1 || read_n !== 1'b1 || write_n !== 1'b1)
            `CHK({p2_out, p2_pu}, {hi, hi})
         @(negedge clock);
         c++;
      end
      `CHK(c, (k == 2'h0) ? 6 : 9)
      `CHK(nf, (k == 2'h0) ? 2 : 0)
      `CHK(nr, (k == 2'h1) ? 3 : 0)
      `CHK(nw, (k == 2'h2) ? 3 : 0)
      `CHK(nl, nl_exp)
      if (k != 2'h2 && nl_exp > 0)
         `CHK(rdata, a[7:0] ^ hi ^ ((k == 2'h0) ? 8'hA5 : 8'h5A))
      if (k == 2'h2) `CHK({wr_addr, wr_data}, {hi, a[7:0], w})
   endtask

   task automatic t_reset;
      repeat (16) @(negedge clock);
      `CHK({fetch_n, read_n, write_n, lp, allow}, 5'h1D)
      resetn = 1'b1;
      @(negedge clock);
      `CHK({allow, req_ready}, 2'h3)
      $display("reset test done");
   endtask

   task automatic t_fetch;
      acc(2'h0, 1'b0, 16'h3C5A, 8'h00, 1);
      acc(2'h0, 1'b1, 16'hA50F, 8'h00, 1);
      $display("fetch test done");
   endtask

   task automatic t_data;
      acc(2'h1, 1'b0, 16'h7E81, 8'h00, 1);
      acc(2'h1, 1'b1, 16'hC33C, 8'h00, 1);
      acc(2'h2, 1'b0, 16'h12F0, 8'hB4, 1);
      acc(2'h2, 1'b1, 16'hFF01, 8'h4B, 1);
      $display("data test done");
   endtask

   task automatic t_gate;
      cfg_val = 1'b0;
      cfg_wr = 1'b1;
      @(negedge clock);
      cfg_wr = 1'b0;
      `CHK(allow, 1'b0)
      ecs_n = 1'b1;
      repeat (4) @(negedge clock);
      acc(2'h0, 1'b0, 16'h0123, 8'h00, 0);
      acc(2'h1, 1'b0, 16'h0456, 8'h00, 1);
      ecs_n = 1'b0;
      repeat (4) @(negedge clock);
      acc(2'h0, 1'b0, 16'h0789, 8'h00, 1);
      cfg_val = 1'b1;
      cfg_wr = 1'b1;
      @(negedge clock);
      cfg_wr = 1'b0;
      $display("latch gating test done");
   endtask

   // clock enable low in mid access must hold every pin and stretch the cycle
   task automatic t_freeze;
      int c;
      wait_ready();
      req_kind = 2'h1;
      req_short = 1'b0;
      req_addr = 16'h5AC3;
      req = 1'b1;
      @(negedge clock);
      req = 1'b0;
      ce = 1'b0;
      repeat (5) @(negedge clock);
      `CHK({fill, lp, read_n, req_ready}, 4'hA)
      ce = 1'b1;
      c = 1;
      while (done !== 1'b1 && c < 12) begin
         @(negedge clock);
         c++;
      end
      `CHK(c, 9)
      `CHK(rdata, 8'hC3 ^ 8'h5A ^ 8'h5A)
      $display("clock enable test done");
   endtask

   // synchroniser needs a few cycles before the pin shows
   task automatic t_code;
      ecs_n = 1'b1;
      pc = 16'h1FFF;
      repeat (4) @(negedge clock);
      `CHK(code_ext, 1'b0)
      pc = 16'h2000;
      repeat (4) @(negedge clock);
      `CHK(code_ext, 1'b1)
      ecs_n = 1'b0;
      pc = 16'h0000;
      repeat (4) @(negedge clock);
      `CHK(code_ext, 1'b1)
      $display("code select test done");
   endtask

   initial begin
      t_reset();
      t_fetch();
      t_data();
      t_freeze();
      t_gate();
      t_code();
      close_out();
   end
endmodule // tb_external_memory_bus_interface

`default_nettype wire
